// *** common/gst_regs.svh ***
/*
  Register offsets, field positions, reset values and counts for the gated sixteen bit timer.
  Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
*/
`ifndef GST_REGS_SVH
`define GST_REGS_SVH

// Byte offsets
`define GST_OFS_TIMER_CONTROL 4'h0
`define GST_OFS_COUNT_LOW 4'h4
`define GST_OFS_COUNT_HIGH 4'h8
`define GST_OFS_GATE_SOURCE 4'hC
`define GST_OFS_INT_CONTROL 5'h10
`define GST_OFS_PERIPH_IE 5'h14
`define GST_OFS_PERIPH_IF 5'h18
`define GST_OFS_SYSTEM 5'h1C

// Timer control fields
`define GST_TC_GATE_INVERT 7
`define GST_TC_GATE_ENABLE 6
`define GST_TC_PRESCALE_HI 5
`define GST_TC_PRESCALE_LO 4
`define GST_TC_CRYSTAL_OSC_ENABLE 3
`define GST_TC_EXT_SYNC_DISABLE 2
`define GST_TC_CLOCK_SOURCE_SELECT 1
`define GST_TC_TIMER_ON 0

// Gate source select fields
`define GST_GS_GATE_SOURCE_SEL 1
`define GST_GS_COMPARATOR_OUTPUT_SYNC 0

// Interrupt control fields
`define GST_IC_GLOBAL_INT_ENABLE 7
`define GST_IC_PERIPHERAL_INT_ENABLE 6

// Peripheral enable and flag position
`define GST_PI_ROLLOVER 0

// System register fields
`define GST_SYS_SLEEP 0
`define GST_SYS_INTERNAL_OSCILLATOR_NO_CLKOUT 1

// Reset values
`define GST_RST_TIMER_CONTROL 8'h00
`define GST_RST_GATE_SOURCE 8'h02
`define GST_RST_INT_CONTROL 8'h00
`define GST_RST_PERIPH_IE 8'h00
`define GST_RST_PERIPH_IF 8'h00
`define GST_RST_COUNT 16'h0000
`define GST_COUNT_MAX 16'hFFFF

// Service routine vector
`define GST_ISR_VECTOR 16'h0004

// Instruction clock is the system clock divided by four
`define GST_INSTR_DIV 2'h3

`endif

// *** common/gst_pkg.sv ***
/*
  Types for the gated sixteen bit timer.
  Assumes gst_regs.svh is compiled alongside.
*/
package gst_pkg;
  typedef enum logic [1:0] {GST_PS_1, GST_PS_2, GST_PS_4, GST_PS_8} gst_prescale_t;
  typedef enum logic [1:0] {GST_BUS_IDLE, GST_BUS_ACK} gst_bus_state_t;
endpackage

// *** src/gst_timer.sv ***
/*
  Gated sixteen bit timer with prescaler, gate and rollover flag behind an Avalon-MM slave.
  Assumes all pin inputs are synchronous to clk; the external clock pin is sampled.
*/
`timescale 1ns/1ps
`include "gst_regs.svh"

// Summary of operation
// - Count bytes read back a coherent value even with unsynchronised external clock.
// - Gate comes from gate pin or second comparator output per source select.
// - Gate affects counting only when gate enable is set.
// - Gate invert one counts on high gate, zero counts on low gate.
// - Gate enable ignored when off; set means count only while gate active.
// - Count wraps FFFF to 0000 and sets rollover flag each wrap.
// - Interrupt request needs rollover enable, peripheral enable and global enable.
// - Counting in sleep only asynchronous external; wake needs on, enable, peripheral.
// - After wake next instruction runs; with global enable vector to 0004h.
// - External mode counts rising edges only after a falling edge is seen.
// - Prescale field divides input by 1, 2, 4 or 8.
// - Crystal oscillator enable honoured only with internal oscillator without clock out.
// - Sync bit one leaves external clock unsynchronised, zero synchronises it.
// - Clock source one selects external pin rising edge, zero instruction clock.
// - Timer on bit enables counting when one, stops when zero.
// - Only the second comparator output can be resynchronised before the gate.
// - Writing a count byte loads the counter and clears the prescaler.
// - Mode switches may drop or add one increment; tolerated.

module gst_timer
  import gst_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  input wire logic external_clock_pin,
  input wire logic crystal_clock,
  input wire logic gate_pin,
  input wire logic second_comparator_output,
  output logic crystal_osc_on,
  output logic interrupt_request,
  output logic wake_request,
  output logic [15:0] vector_address
);
  import gst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] timer_control_r;
  logic [7:0] gate_source_select_r;
  logic [7:0] interrupt_control_r;
  logic [7:0] peripheral_interrupt_enable_r;
  logic [7:0] peripheral_interrupt_flags_r;
  logic [1:0] system_r;
  logic [15:0] count_r;
  logic [2:0] prescale_r;
  logic [1:0] instr_div_r;
  logic [1:0] ext_sync_r;
  logic ext_prev_r;
  logic ext_armed_r;
  logic gate_sync_r;
  gst_bus_state_t bus_state_r;
  logic crystal_osc_on_r;

  logic gate_invert;
  logic gate_enable;
  gst_prescale_t prescale_select;
  logic crystal_osc_enable;
  logic ext_sync_disable;
  logic clock_source_select;
  logic timer_on;
  logic gate_source_sel;
  logic comparator_output_sync;
  logic global_int_enable;
  logic peripheral_int_enable;
  logic rollover_int_enable;
  logic rollover_flag;
  logic sleeping;
  logic internal_oscillator_no_clkout;
  logic wake_cond;
  logic irq_cond;

  assign gate_invert = timer_control_r[`GST_TC_GATE_INVERT];
  assign gate_enable = timer_control_r[`GST_TC_GATE_ENABLE];
  assign prescale_select =
    gst_prescale_t'(timer_control_r[`GST_TC_PRESCALE_HI:`GST_TC_PRESCALE_LO]);
  assign crystal_osc_enable = timer_control_r[`GST_TC_CRYSTAL_OSC_ENABLE];
  assign ext_sync_disable = timer_control_r[`GST_TC_EXT_SYNC_DISABLE];
  assign clock_source_select = timer_control_r[`GST_TC_CLOCK_SOURCE_SELECT];
  assign timer_on = timer_control_r[`GST_TC_TIMER_ON];
  assign gate_source_sel = gate_source_select_r[`GST_GS_GATE_SOURCE_SEL];
  assign comparator_output_sync = gate_source_select_r[`GST_GS_COMPARATOR_OUTPUT_SYNC];
  assign global_int_enable = interrupt_control_r[`GST_IC_GLOBAL_INT_ENABLE];
  assign peripheral_int_enable = interrupt_control_r[`GST_IC_PERIPHERAL_INT_ENABLE];
  assign rollover_int_enable = peripheral_interrupt_enable_r[`GST_PI_ROLLOVER];
  assign rollover_flag = peripheral_interrupt_flags_r[`GST_PI_ROLLOVER];
  assign sleeping = system_r[`GST_SYS_SLEEP];
  assign internal_oscillator_no_clkout = system_r[`GST_SYS_INTERNAL_OSCILLATOR_NO_CLKOUT];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic access;
  logic wr_hit;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_flags;
  logic mapped;

  assign access = (avs_read || avs_write) && bus_state_r == GST_BUS_IDLE;
  assign wr_hit = avs_write && bus_state_r == GST_BUS_IDLE && avs_byteenable[0];
  assign wr_count_low = wr_hit && avs_address == 5'(`GST_OFS_COUNT_LOW);
  assign wr_count_high = wr_hit && avs_address == 5'(`GST_OFS_COUNT_HIGH);
  assign wr_flags = wr_hit && avs_address == `GST_OFS_PERIPH_IF;

  always_comb
  begin
    case (avs_address)
      5'(`GST_OFS_TIMER_CONTROL), 5'(`GST_OFS_COUNT_LOW), 5'(`GST_OFS_COUNT_HIGH),
      5'(`GST_OFS_GATE_SOURCE), `GST_OFS_INT_CONTROL, `GST_OFS_PERIPH_IE,
      `GST_OFS_PERIPH_IF, `GST_OFS_SYSTEM: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and increment enable
  logic instr_tick;
  logic ext_level;
  logic ext_rise;
  logic gate_raw;
  logic gate_level;
  logic gate_active;
  logic input_tick;
  logic prescale_done;
  logic count_run;
  logic increment;
  logic async_mode;

  assign instr_tick = instr_div_r == `GST_INSTR_DIV;
  // Crystal replaces the pin only where the oscillator may run
  assign crystal_osc_on = crystal_osc_on_r;
  assign ext_level = (crystal_osc_enable && internal_oscillator_no_clkout) ? crystal_clock
                     : external_clock_pin;
  assign async_mode = clock_source_select && ext_sync_disable;

  // Gate source, comparator output optionally resynchronised
  assign gate_raw = gate_source_sel ? gate_pin
                    : (comparator_output_sync ? gate_sync_r : second_comparator_output);
  assign gate_level = gate_invert ? gate_raw : ~gate_raw;
  assign gate_active = gate_enable ? gate_level : 1'b1;

  // Synchronised path uses second flop only; async path samples raw level
  assign ext_rise = ext_armed_r && (ext_sync_disable ? (ext_level && !ext_prev_r)
                                    : (ext_sync_r[1] && !ext_prev_r));
  assign input_tick = clock_source_select ? ext_rise : instr_tick;
  assign count_run = timer_on && gate_active && (!sleeping || async_mode);

  always_comb
  begin
    case (prescale_select)
      GST_PS_1: prescale_done = 1'b1;
      GST_PS_2: prescale_done = prescale_r[0];
      GST_PS_4: prescale_done = &prescale_r[1:0];
      GST_PS_8: prescale_done = &prescale_r;
      default: prescale_done = 1'b1;
    endcase
  end
  assign increment = count_run && input_tick && prescale_done;

  ////////////////////////////////////////////////////////////////////////////
  // Dividers and synchronisers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      instr_div_r <= 2'h0;
    else if (!sleeping)
      instr_div_r <= instr_div_r + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ext_sync_r <= 2'b00;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[0], ext_level};
      ext_prev_r <= ext_sync_disable ? ext_level : ext_sync_r[1];
    end
  end

  // Comparator output resample
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      gate_sync_r <= 1'b0;
    else
      gate_sync_r <= second_comparator_output;
  end

  // Arm only after a falling edge; disarm when counter mode or timer on is cleared
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ext_armed_r <= 1'b0;
    else if (!clock_source_select || !timer_on)
      ext_armed_r <= 1'b0;
    else if (ext_prev_r && !(ext_sync_disable ? ext_level : ext_sync_r[1]))
      ext_armed_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prescale_r <= 3'h0;
    else if (wr_count_low || wr_count_high)
      prescale_r <= 3'h0;
    else if (count_run && input_tick)
      prescale_r <= prescale_r + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, bus write wins over increment
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      count_r <= `GST_RST_COUNT;
    else if (wr_count_low)
      count_r[7:0] <= avs_writedata[7:0];
    else if (wr_count_high)
      count_r[15:8] <= avs_writedata[7:0];
    else if (increment)
      count_r <= count_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      timer_control_r <= `GST_RST_TIMER_CONTROL;
      gate_source_select_r <= `GST_RST_GATE_SOURCE;
      interrupt_control_r <= `GST_RST_INT_CONTROL;
      peripheral_interrupt_enable_r <= `GST_RST_PERIPH_IE;
    end
    else if (wr_hit)
    begin
      case (avs_address)
        5'(`GST_OFS_TIMER_CONTROL): timer_control_r <= avs_writedata[7:0];
        5'(`GST_OFS_GATE_SOURCE): gate_source_select_r <= {6'h00, avs_writedata[1:0]};
        `GST_OFS_INT_CONTROL: interrupt_control_r <= avs_writedata[7:0];
        `GST_OFS_PERIPH_IE: peripheral_interrupt_enable_r <= avs_writedata[7:0];
        default: timer_control_r <= timer_control_r;
      endcase
    end
  end

  // System bits: sleep drops on wake
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      system_r <= 2'b00;
    else if (wr_hit && avs_address == `GST_OFS_SYSTEM)
      system_r <= avs_writedata[1:0];
    else if (wake_cond)
      system_r[`GST_SYS_SLEEP] <= 1'b0;
  end

  // Rollover flag: hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      peripheral_interrupt_flags_r <= `GST_RST_PERIPH_IF;
    else
    begin
      if (wr_flags)
        peripheral_interrupt_flags_r <= avs_writedata[7:0];
      if (increment && count_r == `GST_COUNT_MAX)
        peripheral_interrupt_flags_r[`GST_PI_ROLLOVER] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, wake and vector outputs
  assign irq_cond = rollover_flag && rollover_int_enable && peripheral_int_enable
                    && global_int_enable;
  assign wake_cond = sleeping && timer_on && rollover_int_enable && peripheral_int_enable
                     && rollover_flag;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      interrupt_request <= 1'b0;
    else
      interrupt_request <= irq_cond;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      wake_request <= 1'b0;
    else
      wake_request <= wake_cond;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      vector_address <= 16'h0000;
    else
      vector_address <= irq_cond ? `GST_ISR_VECTOR : 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      crystal_osc_on_r <= 1'b0;
    else
      crystal_osc_on_r <= crystal_osc_enable && internal_oscillator_no_clkout;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, answer on the second
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      bus_state_r <= GST_BUS_IDLE;
    else
    begin
      case (bus_state_r)
        GST_BUS_IDLE: if (access) bus_state_r <= GST_BUS_ACK;
        GST_BUS_ACK: bus_state_r <= GST_BUS_IDLE;
        default: bus_state_r <= GST_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response_err <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !access;
      avs_response_err <= access && !mapped;
      if (access && avs_read)
      begin
        case (avs_address)
          5'(`GST_OFS_TIMER_CONTROL): avs_readdata <= {24'h00_0000, timer_control_r};
          // Bytes come from the live synchronous count, never torn within a byte
          5'(`GST_OFS_COUNT_LOW): avs_readdata <= {24'h00_0000, count_r[7:0]};
          5'(`GST_OFS_COUNT_HIGH): avs_readdata <= {24'h00_0000, count_r[15:8]};
          5'(`GST_OFS_GATE_SOURCE): avs_readdata <= {24'h00_0000, gate_source_select_r};
          `GST_OFS_INT_CONTROL: avs_readdata <= {24'h00_0000, interrupt_control_r};
          `GST_OFS_PERIPH_IE: avs_readdata <= {24'h00_0000, peripheral_interrupt_enable_r};
          `GST_OFS_PERIPH_IF: avs_readdata <= {24'h00_0000, peripheral_interrupt_flags_r};
          `GST_OFS_SYSTEM: avs_readdata <= {30'h0000_0000, system_r};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // gst_timer

// *** sim/gst_timer_chk.sv ***
/*
  Port-level assertions and covers for gst_timer.
  Assumes it is bound to every gst_timer instance.
*/
`timescale 1ns/1ps
`include "gst_regs.svh"
module gst_timer_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err,
  input wire logic crystal_osc_on,
  input wire logic interrupt_request,
  input wire logic wake_request,
  input wire logic [15:0] vector_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////////////////////////
  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_err_only; avs_response_err |-> !avs_waitrequest; endproperty
  property p_err_bad;
    !avs_waitrequest && avs_address[1:0] != 2'b00 |-> avs_response_err;
  endproperty
  property p_err_ok;
    !avs_waitrequest && avs_address[1:0] == 2'b00 |-> !avs_response_err;
  endproperty
  property p_rdata; !avs_read |=> $stable(avs_readdata); endproperty
  property p_vector;
    vector_address == (interrupt_request ? `GST_ISR_VECTOR : 16'h0000);
  endproperty
  property p_irq_hold;
    interrupt_request && !avs_write && !$past(avs_write) |=> interrupt_request;
  endproperty
  property p_xtal;
    avs_write && !avs_waitrequest && avs_address == `GST_OFS_TIMER_CONTROL && avs_byteenable[0]
      && !avs_writedata[3] |-> ##[1:2] !crystal_osc_on;
  endproperty
  a_answer: assert property (p_answer) else $error("Request not answered");
  a_one: assert property (p_one) else $error("Answer longer than one cycle");
  a_err_only: assert property (p_err_only) else $error("Error outside answer");
  a_err_bad: assert property (p_err_bad) else $error("Unmapped access not refused");
  a_err_ok: assert property (p_err_ok) else $error("Mapped access refused");
  a_rdata: assert property (p_rdata) else $error("Read data moved");
  a_vector: assert property (p_vector) else $error("Vector mismatch");
  a_irq_hold: assert property (p_irq_hold) else $error("Request dropped");
  a_xtal: assert property (p_xtal) else $error("Crystal left on");
  c_irq: cover property (interrupt_request);
  c_wake: cover property (wake_request);
  c_err: cover property (avs_response_err);
endmodule // gst_timer_chk

bind gst_timer gst_timer_chk gst_timer_chk_i (.clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .avs_response_err, .crystal_osc_on, .interrupt_request, .wake_request, .vector_address);

// *** sim/gst_far_side.sv ***
/*
  Far-side model: external clock pin, crystal clock and gate sources.
  Assumes the bench sets run and gate levels just after clk edges.
*/
`timescale 1ns/1ps
module gst_far_side (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic gate_lvl,
  input wire logic comp_lvl,
  output logic external_clock_pin,
  output logic crystal_clock,
  output logic gate_pin,
  output logic second_comparator_output
);
  logic [1:0] div_r;
  logic [2:0] xdiv_r;
  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Pin clock starts low, toggles every four cycles while run, stands still otherwise
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      div_r <= 2'h0;
      external_clock_pin <= 1'b0;
    end
    else if (run)
    begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3)
        external_clock_pin <= ~external_clock_pin;
    end
  end
  // Crystal runs free
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      xdiv_r <= 3'h0;
    else
      xdiv_r <= xdiv_r + 3'h1;
  end
  assign crystal_clock = xdiv_r[2];
  assign gate_pin = gate_lvl;
  assign second_comparator_output = comp_lvl;
endmodule // gst_far_side

// *** sim/testbench.sv ***
/*
  Self-checking bench for gst_timer with the far-side model.
  Assumes package, register header, design, model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "gst_regs.svh"
module testbench;
  import gst_pkg::*;
  localparam logic [4:0] a_tc = `GST_OFS_TIMER_CONTROL, a_lo = `GST_OFS_COUNT_LOW;
  localparam logic [4:0] a_hi = `GST_OFS_COUNT_HIGH, a_gs = `GST_OFS_GATE_SOURCE;
  localparam logic [4:0] a_ic = `GST_OFS_INT_CONTROL, a_ie = `GST_OFS_PERIPH_IE;
  localparam logic [4:0] a_if = `GST_OFS_PERIPH_IF, a_sys = `GST_OFS_SYSTEM;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, avs_response_err, rerr, run;
  logic external_clock_pin, crystal_clock, gate_pin, second_comparator_output, gate_lvl, comp_lvl;
  logic crystal_osc_on, interrupt_request, wake_request;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] vector_address;
  logic [7:0] rv;
  logic [15:0] gtab [9] = '{16'h2C10, 16'h2C15, 16'h2414, 16'h2411, 16'h0C14, 16'h0C13,
    16'h2011, 16'h2C04, 16'h1C13};
  logic [11:0] etab [3] = '{12'h032, 12'h072, 12'h171};
  int mismatches, samples_checked;
  gst_timer gst_timer_i (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .external_clock_pin,
    .crystal_clock, .gate_pin, .second_comparator_output, .crystal_osc_on, .interrupt_request,
    .wake_request, .vector_address);
  gst_far_side gst_far_side_i (.clk, .reset_n, .run, .gate_lvl, .comp_lvl, .external_clock_pin,
    .crystal_clock, .gate_pin, .second_comparator_output);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    rv = avs_readdata[7:0];
    rerr = avs_response_err;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      summarize();
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00, 4'h1);
  endtask
  task set_count(input logic [7:0] v);
    wr(a_tc, 8'h00);
    wr(a_lo, v);
    wr(a_hi, v);
  endtask
  task pulse(input int n);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
  endtask
  task wait_irq(input logic wk);
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk);
      if ((wk ? wake_request : interrupt_request) === 1'b1)
        return;
    end
    mismatches++;
    summarize();
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(a_tc);
    chk(rv, 8'h00);
    rd(a_gs);
    chk(rv, 8'h02);
    rd(a_ie);
    chk(rv, 8'h00);
    rd(a_if);
    chk(rv, 8'h00);
    rd(5'h01);
    chk({rerr, rv}, 16'h0100);
    bus(1'b1, a_tc, 8'hFF, 4'h0);
    rd(a_tc);
    chk(rv, 8'h00);
    wr(a_sys, 8'h02);
    wr(a_tc, 8'h08);
    repeat (3) @(posedge clk);
    chk(crystal_osc_on, 1'b1);
    wr(a_tc, 8'h00);
    repeat (2) @(posedge clk);
    chk(crystal_osc_on, 1'b0);
    wr(a_tc, 8'h08);
    wr(a_sys, 8'h00);
    repeat (3) @(posedge clk);
    chk(crystal_osc_on, 1'b0);
    $display("Registers done");
  endtask
  task t_ext;
    set_count(8'h00);
    wr(a_tc, 8'h03);
    pulse(4);
    repeat (8) @(posedge clk);
    rd(a_lo);
    chk(rv, 8'h00);
    pulse(8);
    repeat (8) @(posedge clk);
    rd(a_lo);
    chk(rv, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      set_count(8'h00);
      wr(a_tc, etab[i][11:4]);
      pulse(16);
      repeat (8) @(posedge clk);
      rd(a_lo);
      chk(rv, {4'h0, etab[i][3:0]});
    end
    $display("External clock done");
  endtask
  task t_gate;
    for (int i = 0; i < 9; i++)
    begin
      set_count(8'h00);
      wr(a_gs, {4'h0, gtab[i][15:12]});
      gate_lvl <= gtab[i][2];
      comp_lvl <= gtab[i][1];
      wr(a_tc, gtab[i][11:4]);
      repeat (32) @(posedge clk);
      wr(a_tc, 8'h00);
      rd(a_lo);
      chk(rv != 8'h00, gtab[i][0]);
    end
    $display("Gate done");
  endtask
  task t_pre;
    int e;
    for (int p = 0; p < 4; p++)
    begin
      set_count(8'h00);
      wr(a_tc, {2'b00, p[1:0], 4'h1});
      repeat (96) @(posedge clk);
      wr(a_tc, 8'h00);
      rd(a_lo);
      e = 98 >> (2 + p);
      chk(rv + 1 >= e && rv <= e + 1, 1'b1);
    end
    $display("Prescale done");
  endtask
  task t_int;
    set_count(8'hFF);
    wr(a_lo, 8'hFE);
    wr(a_if, 8'h00);
    wr(a_ie, 8'h01);
    wr(a_ic, 8'hC0);
    wr(a_tc, 8'h01);
    wait_irq(1'b0);
    chk(vector_address, `GST_ISR_VECTOR);
    rd(a_hi);
    chk(rv, 8'h00);
    rd(a_if);
    chk(rv, 8'h01);
    repeat (20) @(posedge clk);
    chk(interrupt_request, 1'b1);
    wr(a_tc, 8'h00);
    wr(a_if, 8'h00);
    repeat (3) @(posedge clk);
    chk(interrupt_request, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(a_ic, i == 0 ? 8'h40 : (i == 1 ? 8'h80 : 8'hC0));
      wr(a_if, 8'h01);
      repeat (3) @(posedge clk);
      chk(interrupt_request, i == 2);
    end
    wr(a_if, 8'h00);
    wr(a_ic, 8'h00);
    $display("Interrupt done");
  endtask
  task t_sleep;
    set_count(8'hFF);
    wr(a_if, 8'h00);
    wr(a_ie, 8'h01);
    wr(a_ic, 8'h40);
    wr(a_sys, 8'h01);
    wr(a_tc, 8'h07);
    run <= 1'b1;
    wait_irq(1'b1);
    run <= 1'b0;
    chk(interrupt_request, 1'b0);
    chk(vector_address, 16'h0000);
    rd(a_sys);
    chk(rv, 8'h00);
    wr(a_tc, 8'h00);
    wr(a_if, 8'h00);
    $display("Sleep done");
  endtask
  initial
  begin
    reset_n = 1'b0;
    {avs_read, avs_write, run, gate_lvl, comp_lvl} = 5'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_ext();
    t_gate();
    t_pre();
    t_int();
    t_sleep();
    summarize();
  end
endmodule // testbench
